// *** src/tsq_map.svh ***
`ifndef TSQ_MAP_SVH
`define TSQ_MAP_SVH

// register offsets (byte addresses, one 32-bit word each)
`define TSQ_REG_CTRL      8'h00
`define TSQ_REG_SRC_A     8'h04
`define TSQ_REG_SRC_B     8'h08
`define TSQ_REG_SRC_R     8'h0C
`define TSQ_REG_LVL_A     8'h10
`define TSQ_REG_LVL_B     8'h14
`define TSQ_REG_LVL_R     8'h18
`define TSQ_REG_DELAY     8'h1C
`define TSQ_REG_COUNT     8'h20
`define TSQ_REG_TIMEOUT   8'h24
`define TSQ_REG_HOLDOFF   8'h28
`define TSQ_REG_PRE       8'h2C
`define TSQ_REG_POST      8'h30
`define TSQ_REG_STATUS    8'h34
`define TSQ_REG_CMD       8'h38

// control register fields
`define TSQ_CTRL_SEQ_BIT     0
`define TSQ_CTRL_ZONE_BIT    1
`define TSQ_CTRL_RST_EV_BIT  2
`define TSQ_CTRL_RST_TO_BIT  3
`define TSQ_CTRL_TOUT_BIT    4
`define TSQ_CTRL_ARM_BIT     5

// event setup fields: source in [4:0], type in [11:8]
`define TSQ_SRC_LSB   0
`define TSQ_SRC_MSB   4
`define TSQ_TYPE_LSB  8
`define TSQ_TYPE_MSB  11

// command register bits
`define TSQ_CMD_FIND_BIT  0

// source codes: 0..7 analog, 8 extern, 9 line, 16..31 logic, 10 bus
`define TSQ_SRC_EXTERN  5'h08
`define TSQ_SRC_LINE    5'h09
`define TSQ_SRC_BUS     5'h0A
`define TSQ_SRC_ANA_MAX 5'h07
`define TSQ_SRC_DIG_MIN 5'h10

// reset values
`define TSQ_CTRL_RESET  32'h00000000
`define TSQ_COUNT_RESET 16'h0001
`define TSQ_SRC_RESET   5'h00

`endif

// *** src/tsq_pkg.sv ***
package tsq_pkg;

    typedef enum logic [3:0] {
        TSQ_EDGE, TSQ_GLITCH, TSQ_WIDTH, TSQ_RUNT, TSQ_WINDOW, TSQ_TIMEOUT,
        TSQ_INTERVAL, TSQ_SLEW, TSQ_SETUP_HOLD, TSQ_STATE, TSQ_PATTERN,
        TSQ_ANA_EDGE
    } tsq_trig_type;

    typedef enum {
        TSQ_ACQ_IDLE, TSQ_ACQ_PRE, TSQ_ACQ_ARMED, TSQ_ACQ_POST,
        TSQ_ACQ_HOLDOFF
    } tsq_acq_type;

    typedef enum {
        TSQ_SEQ_WAIT_A, TSQ_SEQ_DELAY, TSQ_SEQ_COUNT_B
    } tsq_seq_type;

endpackage

// *** src/tsq_acq_control.sv ***
// Summary of operation
// - trigger fires only when all conditions of the active setup match together
// - while armed, sample continuously and hold the pre-trigger samples
// - after trigger, fill post-trigger part, then halt and await next
// - ignore triggers until acquisition done and holdoff expired
// - find level sets threshold to half of max peak minus min peak
// - in sequence mode find level updates A and B thresholds, and R only when the reset event is enabled
// - find level refused for extern and line sources
// - arm B detection only after A met and delay fully expired
// - count qualifying B events up to programmed count, one allowed
// - B event reaching count triggers, then sequence restarts at A
// - B events before A or during delay are not counted
// - reset condition may be timeout, reset event, or both
// - sequence sources must be analog channels; bad settings corrected
// - setup-hold, state, pattern types only in single-event mode
// - extern source allows only the analog edge type
// - logic sources allow edge, width, timeout, state, pattern only
// - logic channels and bus sources only in single-event mode
// - line source derives trigger from mains sync, edge type only
// - sequence type selects A-B-R or A together with zone condition in the same cycle
// - drive trigger output on each trigger when enabled
// - reset event before count reached abandons count, restarts
// - timeout before count reached restarts from A
`timescale 1ns/1ps
`default_nettype none
`include "tsq_map.svh"

module tsq_acq_control #(
    parameter int SW  = 12,
    parameter int CW  = 32,
    parameter int AW  = 8
) (
    // clock, reset, enable
    input  wire logic          ref_clk,
    input  wire logic          srst,
    input  wire logic          clk_en,
    // register port
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [31:0]        reg_rdata,
    // sample stream and per-event condition matches (same clock)
    input  wire logic [SW-1:0] sample,
    input  wire logic          cond_a,
    input  wire logic          cond_b,
    input  wire logic          cond_r,
    input  wire logic          zone_hit,
    // mains sync comes from outside the clock domain
    input  wire logic          line_sync,
    // acquisition outputs
    output logic               sample_we,
    output logic               trig_out,
    output logic               acq_done
);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [31:0]   ctrl;
    logic [31:0]   src_a;
    logic [31:0]   src_b;
    logic [31:0]   src_r;
    logic [SW-1:0] lvl_a;
    logic [SW-1:0] lvl_b;
    logic [SW-1:0] lvl_r;
    logic [CW-1:0] delay_cyc;
    logic [15:0]   count_b;
    logic [CW-1:0] tout_cyc;
    logic [CW-1:0] holdoff_cyc;
    logic [CW-1:0] pre_cyc;
    logic [CW-1:0] post_cyc;
    logic          find_rej;
    logic          fix_done;

    // ------------------------------------------------------------
    // configuration checks
    // ------------------------------------------------------------
    function automatic logic is_ana(input logic [4:0] s);
        is_ana = (s <= `TSQ_SRC_ANA_MAX);
    endfunction
    function automatic logic type_ok(input logic [4:0] s,
                                     input logic [3:0] t,
                                     input logic       seq);
        type_ok = 1'b1;
        if (s == `TSQ_SRC_EXTERN)
            type_ok = (t == tsq_pkg::TSQ_ANA_EDGE);
        else if (s == `TSQ_SRC_LINE)
            type_ok = (t == tsq_pkg::TSQ_EDGE);
        else if (s >= `TSQ_SRC_DIG_MIN)
            type_ok = (t == tsq_pkg::TSQ_EDGE) || (t == tsq_pkg::TSQ_WIDTH) ||
                      (t == tsq_pkg::TSQ_TIMEOUT) ||
                      (t == tsq_pkg::TSQ_STATE) ||
                      (t == tsq_pkg::TSQ_PATTERN);
        else if (t == tsq_pkg::TSQ_ANA_EDGE)
            type_ok = 1'b0;
        if (seq && ((t == tsq_pkg::TSQ_SETUP_HOLD) ||
                    (t == tsq_pkg::TSQ_STATE) ||
                    (t == tsq_pkg::TSQ_PATTERN)))
            type_ok = 1'b0;
    endfunction
    // correct a source word to something that fits
    function automatic logic [31:0] fix_src(input logic [31:0] w,
                                            input logic        seq);
        logic [4:0]  s;
        logic [3:0]  t;
        logic [31:0] r;
        s = w[`TSQ_SRC_MSB:`TSQ_SRC_LSB];
        t = w[`TSQ_TYPE_MSB:`TSQ_TYPE_LSB];
        r = w;
        if (seq && !is_ana(s))
            s = `TSQ_SRC_RESET;
        if (!type_ok(s, t, seq))
            t = (s == `TSQ_SRC_EXTERN) ? 4'(tsq_pkg::TSQ_ANA_EDGE)
                                       : 4'(tsq_pkg::TSQ_EDGE);
        r[`TSQ_SRC_MSB:`TSQ_SRC_LSB]   = s;
        r[`TSQ_TYPE_MSB:`TSQ_TYPE_LSB] = t;
        fix_src = r;
    endfunction
    logic seq_mode;
    logic zone_mode;
    logic arm;
    assign seq_mode  = ctrl[`TSQ_CTRL_SEQ_BIT];
    assign zone_mode = ctrl[`TSQ_CTRL_ZONE_BIT];
    assign arm       = ctrl[`TSQ_CTRL_ARM_BIT];

    // ------------------------------------------------------------
    // peak tracker for automatic level
    // ------------------------------------------------------------
    logic [SW-1:0] pk_max;
    logic [SW-1:0] pk_min;
    logic [SW-1:0] auto_lvl;
    logic          find_req;
    assign auto_lvl = SW'((pk_max - pk_min) >> 1);
    assign find_req = clk_en && reg_wr && (reg_addr == AW'(`TSQ_REG_CMD)) &&
                      reg_wdata[`TSQ_CMD_FIND_BIT];
    // a find opens a fresh peak window
    always_ff @(posedge ref_clk) begin
        if (srst || find_req) begin
            pk_max <= '0;
            pk_min <= '1;
        end else if (clk_en) begin
            if (sample > pk_max)
                pk_max <= sample;
            if (sample < pk_min)
                pk_min <= sample;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    logic find_bad;
    // no auto level on extern or line
    assign find_bad = (src_a[4:0] == `TSQ_SRC_EXTERN) ||
                      (src_a[4:0] == `TSQ_SRC_LINE);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl        <= `TSQ_CTRL_RESET;
            src_a       <= '0;
            src_b       <= '0;
            src_r       <= '0;
            lvl_a       <= '0;
            lvl_b       <= '0;
            lvl_r       <= '0;
            delay_cyc   <= '0;
            count_b     <= `TSQ_COUNT_RESET;
            tout_cyc    <= '0;
            holdoff_cyc <= '0;
            pre_cyc     <= '0;
            post_cyc    <= '0;
            find_rej    <= 1'b0;
            fix_done    <= 1'b0;
        end else if (clk_en) begin
            if (reg_wr) begin
                unique case (reg_addr)
                    AW'(`TSQ_REG_CTRL): begin
                        ctrl     <= reg_wdata;
                        src_a    <= fix_src(src_a, reg_wdata[0]);
                        src_b    <= fix_src(src_b, reg_wdata[0]);
                        src_r    <= fix_src(src_r, reg_wdata[0]);
                        fix_done <= 1'b1;
                    end
                    AW'(`TSQ_REG_SRC_A):   src_a <= fix_src(reg_wdata, seq_mode);
                    AW'(`TSQ_REG_SRC_B):   src_b <= fix_src(reg_wdata, 1'b1);
                    AW'(`TSQ_REG_SRC_R):   src_r <= fix_src(reg_wdata, 1'b1);
                    AW'(`TSQ_REG_LVL_A):   lvl_a <= reg_wdata[SW-1:0];
                    AW'(`TSQ_REG_LVL_B):   lvl_b <= reg_wdata[SW-1:0];
                    AW'(`TSQ_REG_LVL_R):   lvl_r <= reg_wdata[SW-1:0];
                    AW'(`TSQ_REG_DELAY):   delay_cyc <= reg_wdata[CW-1:0];
                    AW'(`TSQ_REG_COUNT):   count_b <= (reg_wdata[15:0] == 16'h0000)
                                              ? 16'h0001 : reg_wdata[15:0];
                    AW'(`TSQ_REG_TIMEOUT): tout_cyc <= reg_wdata[CW-1:0];
                    AW'(`TSQ_REG_HOLDOFF): holdoff_cyc <= reg_wdata[CW-1:0];
                    AW'(`TSQ_REG_PRE):     pre_cyc <= reg_wdata[CW-1:0];
                    AW'(`TSQ_REG_POST):    post_cyc <= reg_wdata[CW-1:0];
                    AW'(`TSQ_REG_CMD): begin
                        if (reg_wdata[`TSQ_CMD_FIND_BIT]) begin
                            find_rej <= find_bad;
                            if (!find_bad) begin
                                lvl_a <= auto_lvl;
                                if (seq_mode) begin
                                    lvl_b <= auto_lvl;
                                    if (ctrl[`TSQ_CTRL_RST_EV_BIT])
                                        lvl_r <= auto_lvl;
                                end
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // sequence engine
    // ------------------------------------------------------------
    logic                line_s1;
    logic                line_s2;
    logic                line_d;
    tsq_pkg::tsq_seq_type seq_st;
    logic [CW-1:0]       seq_cnt;
    logic [CW-1:0]       tout_cnt;
    logic [15:0]         b_hits;
    logic                trig_hit;
    logic                ev_a;
    logic                rst_hit;
    logic                accepting;
    // two-flop sync, then edge of the mains reference
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            line_s1 <= 1'b0;
            line_s2 <= 1'b0;
            line_d  <= 1'b0;
        end else if (clk_en) begin
            line_s1 <= line_sync;
            line_s2 <= line_s1;
            line_d  <= line_s2;
        end
    end
    // A event is the full match of the configured condition
    assign ev_a = (src_a[4:0] == `TSQ_SRC_LINE) ? (line_s2 && !line_d)
                                                 : cond_a;
    assign rst_hit = (ctrl[`TSQ_CTRL_RST_EV_BIT] && cond_r) ||
                     (ctrl[`TSQ_CTRL_RST_TO_BIT] && tout_cnt == '0);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            seq_st   <= tsq_pkg::TSQ_SEQ_WAIT_A;
            seq_cnt  <= '0;
            tout_cnt <= '0;
            b_hits   <= '0;
        end else if (clk_en) begin
            unique case (seq_st)
                tsq_pkg::TSQ_SEQ_WAIT_A: begin
                    b_hits <= '0;
                    if (seq_mode && !zone_mode && accepting && ev_a) begin
                        seq_cnt <= delay_cyc;
                        seq_st  <= tsq_pkg::TSQ_SEQ_DELAY;
                    end
                end
                tsq_pkg::TSQ_SEQ_DELAY: begin
                    if (seq_cnt == '0) begin
                        tout_cnt <= tout_cyc;
                        seq_st   <= tsq_pkg::TSQ_SEQ_COUNT_B;
                    end else
                        seq_cnt <= seq_cnt - 1'b1;
                end
                tsq_pkg::TSQ_SEQ_COUNT_B: begin
                    if (tout_cnt != '0)
                        tout_cnt <= tout_cnt - 1'b1;
                    if (rst_hit) begin
                        seq_st <= tsq_pkg::TSQ_SEQ_WAIT_A;
                    end else if (cond_b) begin
                        if (b_hits + 16'h0001 >= count_b)
                            seq_st <= tsq_pkg::TSQ_SEQ_WAIT_A;
                        else
                            b_hits <= b_hits + 16'h0001;
                    end
                end
            endcase
            if (!seq_mode || zone_mode)
                seq_st <= tsq_pkg::TSQ_SEQ_WAIT_A;
        end
    end
    // choose single, A-B-R, or A with zone in the same cycle
    assign trig_hit = !seq_mode ? ev_a
                    : zone_mode ? (ev_a && zone_hit)
                    : (seq_st == tsq_pkg::TSQ_SEQ_COUNT_B) && !rst_hit &&
                      cond_b && (b_hits + 16'h0001 >= count_b);

    // ------------------------------------------------------------
    // acquisition control
    // ------------------------------------------------------------
    tsq_pkg::tsq_acq_type acq_st;
    logic [CW-1:0]        acq_cnt;
    assign accepting = (acq_st == tsq_pkg::TSQ_ACQ_ARMED);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            acq_st    <= tsq_pkg::TSQ_ACQ_IDLE;
            acq_cnt   <= '0;
            sample_we <= 1'b0;
            trig_out  <= 1'b0;
            acq_done  <= 1'b0;
        end else if (clk_en) begin
            trig_out <= 1'b0;
            acq_done <= 1'b0;
            unique case (acq_st)
                tsq_pkg::TSQ_ACQ_IDLE: begin
                    sample_we <= arm;
                    if (arm) begin
                        acq_cnt <= pre_cyc;
                        acq_st  <= tsq_pkg::TSQ_ACQ_PRE;
                    end
                end
                tsq_pkg::TSQ_ACQ_PRE: begin
                    if (acq_cnt == '0)
                        acq_st <= tsq_pkg::TSQ_ACQ_ARMED;
                    else
                        acq_cnt <= acq_cnt - 1'b1;
                end
                tsq_pkg::TSQ_ACQ_ARMED: begin
                    sample_we <= arm;
                    if (!arm)
                        acq_st <= tsq_pkg::TSQ_ACQ_IDLE;
                    else if (trig_hit) begin
                        trig_out <= ctrl[`TSQ_CTRL_TOUT_BIT];
                        acq_cnt  <= post_cyc;
                        acq_st   <= tsq_pkg::TSQ_ACQ_POST;
                    end
                end
                tsq_pkg::TSQ_ACQ_POST: begin
                    if (acq_cnt == '0) begin
                        sample_we <= 1'b0;
                        acq_done  <= 1'b1;
                        acq_cnt   <= holdoff_cyc;
                        acq_st    <= tsq_pkg::TSQ_ACQ_HOLDOFF;
                    end else
                        acq_cnt <= acq_cnt - 1'b1;
                end
                tsq_pkg::TSQ_ACQ_HOLDOFF: begin
                    // no trigger accepted until holdoff expires
                    if (acq_cnt == '0)
                        acq_st <= tsq_pkg::TSQ_ACQ_IDLE;
                    else
                        acq_cnt <= acq_cnt - 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    AW'(`TSQ_REG_CTRL):    reg_rdata <= ctrl;
                    AW'(`TSQ_REG_SRC_A):   reg_rdata <= src_a;
                    AW'(`TSQ_REG_SRC_B):   reg_rdata <= src_b;
                    AW'(`TSQ_REG_SRC_R):   reg_rdata <= src_r;
                    AW'(`TSQ_REG_LVL_A):   reg_rdata <= 32'(lvl_a);
                    AW'(`TSQ_REG_LVL_B):   reg_rdata <= 32'(lvl_b);
                    AW'(`TSQ_REG_LVL_R):   reg_rdata <= 32'(lvl_r);
                    AW'(`TSQ_REG_DELAY):   reg_rdata <= 32'(delay_cyc);
                    AW'(`TSQ_REG_COUNT):   reg_rdata <= 32'(count_b);
                    AW'(`TSQ_REG_TIMEOUT): reg_rdata <= 32'(tout_cyc);
                    AW'(`TSQ_REG_HOLDOFF): reg_rdata <= 32'(holdoff_cyc);
                    AW'(`TSQ_REG_PRE):     reg_rdata <= 32'(pre_cyc);
                    AW'(`TSQ_REG_POST):    reg_rdata <= 32'(post_cyc);
                    AW'(`TSQ_REG_STATUS):
                        reg_rdata <= {16'h0000, b_hits[7:0], 1'b0,
                                      fix_done, find_rej,
                                      2'(seq_st), 3'(acq_st)};
                    default:               reg_rdata <= '0;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// *** tb/tsq_acq_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsq_acq_chk (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // watched ports
    input wire logic        sample_we,
    input wire logic        trig_out,
    input wire logic        acq_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // ----
    // blocked from a trigger until a fresh record starts
    // ----
    logic blk;
    always_ff @(posedge ref_clk) begin
        if (srst)
            blk <= 1'b0;
        else if (trig_out)
            blk <= 1'b1;
        else if ($rose(sample_we))
            blk <= 1'b0;
    end
    property p_trig_one; trig_out |=> !trig_out; endproperty
    a_trig_one: assert property (p_trig_one)
        else $error("trigger output longer than one cycle");
    property p_done_one; acq_done |=> !acq_done; endproperty
    a_done_one: assert property (p_done_one)
        else $error("done pulse longer than one cycle");
    property p_trig_rec;
        trig_out |-> sample_we && $past(sample_we);
    endproperty
    a_trig_rec: assert property (p_trig_rec)
        else $error("trigger without a running record");
    property p_done_stop; acq_done |-> !sample_we; endproperty
    a_done_stop: assert property (p_done_stop)
        else $error("sampling goes on after record end");
    property p_done_due; trig_out |-> ##[1:600] acq_done; endproperty
    a_done_due: assert property (p_done_due)
        else $error("record never completed after trigger");
    property p_hold; blk |-> !trig_out; endproperty
    a_hold: assert property (p_hold)
        else $error("trigger accepted before holdoff ended");
    property p_pre; $rose(sample_we) |-> sample_we [*2]; endproperty
    a_pre: assert property (p_pre)
        else $error("pre-trigger part cut short");
    property p_we_done; $fell(sample_we) |-> acq_done; endproperty
    a_we_done: assert property (p_we_done)
        else $error("sampling stopped without record end");
endmodule
bind tsq_acq_control tsq_acq_chk tsq_acq_chk_inst (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .sample_we (sample_we),
    .trig_out  (trig_out),
    .acq_done  (acq_done)
);
`default_nettype wire

// *** tb/test_trigger_sequencer_acq_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tsq_map.svh"
module test_trigger_sequencer_acq_control;
    logic        ref_clk;
    logic        srst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [11:0] sample;
    logic [3:0]  cnd;
    logic        sample_we;
    logic        trig_out;
    logic        acq_done;
    logic        line_in;
    logic [31:0] rd;
    logic [31:0] n_trig;
    logic [31:0] t0;
    int          n_fail;
    int          checked;
    // ctrl, address, written, read back
    logic [31:0] fix [8][4] = '{
        '{32'h0, 32'h04, 32'h0108, 32'h0B08},
        '{32'h0, 32'h04, 32'h0310, 32'h0010},
        '{32'h0, 32'h04, 32'h0209, 32'h0009},
        '{32'h0, 32'h04, 32'h0910, 32'h0910},
        '{32'h1, 32'h04, 32'h0210, 32'h0200},
        '{32'h1, 32'h04, 32'h0801, 32'h0001},
        '{32'h0, 32'h08, 32'h0A00, 32'h0000},
        '{32'h1, 32'h04, 32'h000A, 32'h0000}};
    tsq_acq_control #(.SW(12), .CW(32), .AW(8)) tsq_acq_control_inst (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .clk_en    (1'b1),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .sample    (sample),
        .cond_a    (cnd[0]),
        .cond_b    (cnd[1]),
        .cond_r    (cnd[2]),
        .zone_hit  (cnd[3]),
        .line_sync (line_in),
        .sample_we (sample_we),
        .trig_out  (trig_out),
        .acq_done  (acq_done)
    );
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (trig_out === 1'b1)
            n_trig <= n_trig + 32'h1;
    end
    // ----
    // access and check tasks
    // ----
    task automatic complete_run;
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_up;
        n_fail++;
        $display("BAD %0t wait ran out", $time);
        complete_run();
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge ref_clk);
        cnd <= m;
        @(posedge ref_clk);
        cnd <= 4'h0;
    endtask
    task automatic do_reset;
        @(posedge ref_clk);
        srst <= 1'b1;
        idle(10);
        srst <= 1'b0;
    endtask
    task automatic wait_armed;
        for (int i = 0; i < 50; i++) begin
            rdr(`TSQ_REG_STATUS);
            if (rd[2:0] === 3'h2)
                return;
        end
        give_up();
    endtask
    task automatic wait_done;
        for (int i = 0; i < 100; i++) begin
            @(posedge ref_clk);
            #1;
            if (acq_done === 1'b1)
                return;
        end
        give_up();
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        srst      = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        sample    = 12'h000;
        cnd       = 4'h0;
        line_in   = 1'b0;
        n_trig    = 32'h0;
        n_fail    = 0;
        checked   = 0;
        idle(10);
        srst <= 1'b0;
        rdr(`TSQ_REG_COUNT);
        check(rd, 32'h1);
        wr(`TSQ_REG_COUNT, 32'h0);
        rdr(`TSQ_REG_COUNT);
        check(rd, 32'h1);
        wr(8'h3C, 32'hFF);
        rdr(8'h3C);
        check(rd, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(`TSQ_REG_CTRL, fix[i][0]);
            wr(fix[i][1][7:0], fix[i][2]);
            rdr(fix[i][1][7:0]);
            check(rd, fix[i][3]);
        end
        do_reset();
        wr(`TSQ_REG_PRE, 32'h2);
        wr(`TSQ_REG_POST, 32'h3);
        wr(`TSQ_REG_HOLDOFF, 32'h4);
        wr(`TSQ_REG_CTRL, 32'h30);
        wait_armed();
        check({31'h0, sample_we}, 32'h1);
        t0 = n_trig;
        pulse(4'h2);
        pulse(4'h8);
        idle(2);
        check(n_trig, t0);
        pulse(4'h1);
        pulse(4'h1);
        wait_done();
        pulse(4'h1);
        idle(2);
        check(n_trig, t0 + 32'h1);
        do_reset();
        wr(`TSQ_REG_CTRL, 32'h20);
        wait_armed();
        t0 = n_trig;
        pulse(4'h1);
        wait_done();
        check(n_trig, t0);
        do_reset();
        wr(`TSQ_REG_CTRL, 32'h33);
        wait_armed();
        t0 = n_trig;
        pulse(4'h1);
        idle(2);
        check(n_trig, t0);
        pulse(4'h9);
        idle(2);
        check(n_trig, t0 + 32'h1);
        do_reset();
        wr(`TSQ_REG_SRC_A, 32'h0009);
        wr(`TSQ_REG_CTRL, 32'h30);
        wait_armed();
        t0 = n_trig;
        pulse(4'h1);
        idle(2);
        check(n_trig, t0);
        line_in <= 1'b1;
        idle(5);
        check(n_trig, t0 + 32'h1);
        line_in <= 1'b0;
        do_reset();
        wr(`TSQ_REG_DELAY, 32'h3);
        wr(`TSQ_REG_COUNT, 32'h2);
        wr(`TSQ_REG_CTRL, 32'h31);
        wait_armed();
        t0 = n_trig;
        pulse(4'h2);
        pulse(4'h1);
        pulse(4'h2);
        idle(6);
        pulse(4'h2);
        idle(2);
        check(n_trig, t0);
        pulse(4'h2);
        idle(2);
        check(n_trig, t0 + 32'h1);
        for (int k = 0; k < 2; k++) begin
            do_reset();
            wr(`TSQ_REG_DELAY, 32'h1);
            wr(`TSQ_REG_COUNT, 32'h2);
            wr(`TSQ_REG_TIMEOUT, 32'h14);
            wr(`TSQ_REG_CTRL, (k == 1) ? 32'h39 : 32'h35);
            wait_armed();
            t0 = n_trig;
            pulse(4'h1);
            idle(3);
            pulse(4'h2);
            if (k == 1)
                idle(30);
            else
                pulse(4'h4);
            pulse(4'h2);
            idle(2);
            check(n_trig, t0);
            pulse(4'h1);
            idle(3);
            pulse(4'h2);
            pulse(4'h2);
            idle(2);
            check(n_trig, t0 + 32'h1);
        end
        do_reset();
        wr(`TSQ_REG_CTRL, 32'h05);
        sample <= 12'h064;
        wr(`TSQ_REG_CMD, 32'h1);
        sample <= 12'h12C;
        idle(3);
        sample <= 12'h064;
        wr(`TSQ_REG_CMD, 32'h1);
        rdr(`TSQ_REG_LVL_A);
        check(rd, 32'h64);
        rdr(`TSQ_REG_LVL_B);
        check(rd, 32'h64);
        rdr(`TSQ_REG_LVL_R);
        check(rd, 32'h64);
        wr(`TSQ_REG_CTRL, 32'h0);
        wr(`TSQ_REG_SRC_A, 32'h0B08);
        sample <= 12'h200;
        wr(`TSQ_REG_CMD, 32'h1);
        rdr(`TSQ_REG_STATUS);
        check({31'h0, rd[5]}, 32'h1);
        rdr(`TSQ_REG_LVL_A);
        check(rd, 32'h64);
        complete_run();
    end
endmodule
`default_nettype wire
